//--- rtl/eci_regs.svh
// Register offsets, field positions, reset values and fixed counts of the card identity block.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef ECI_REGS_SVH
`define ECI_REGS_SVH
// ==========================================================
// Register byte offsets on the AXI4-Lite slave.
`define ECI_OFF_CTRL 8'h00
`define ECI_OFF_STATUS 8'h04
`define ECI_OFF_PTR 8'h08
`define ECI_OFF_DATA 8'h0c
`define ECI_OFF_TYPE 8'h10
`define ECI_OFF_SIZE 8'h14
`define ECI_OFF_START 8'h18
`define ECI_OFF_CMD 8'h1c
// ==========================================================
// Reset values and control fields.
`define ECI_CTRL_RST 3'h0
`define ECI_MODE_NONEXT 2'h0
`define ECI_MODE_EXT 2'h1
`define ECI_MODE_PAGED 2'h2
`define ECI_CTRL_EN_BIT 2
`define ECI_CMD_COMMIT_BIT 0
`define ECI_CMD_TERM_BIT 1
`define ECI_RESP_OKAY 2'h0
`define ECI_RESP_SLVERR 2'h2
// ==========================================================
// Directory entry layout and host space decode.
`define ECI_TYPE_VALID 8'h80
`define ECI_ENTRY_LAST 3'h7
`define ECI_TERM_LAST 3'h3
`define ECI_SPEED_SYNC 2'h3
`define ECI_PAGE_IDX 8'h00
`define ECI_PINS_IDLE 29'h1e00_0000
`endif

//--- rtl/eci_pkg.sv
// Types shared by the card identity block: pin bundle, entry categories and builder states.
// Assumes nothing of its surroundings.
package eci_pkg;
   // ==========================================================
   // Card pins as seen after synchronisation.
   typedef struct packed {
      logic selN;
      logic rdN;
      logic wrN;
      logic rnw;
      logic busClock;
      logic [15:0] addr;
      logic [7:0] data;
   } eci_pins_t;

   // Content category of a directory entry type byte.
   typedef enum logic [3:0] {
      CAT_LOADER = 4'h0,
      CAT_LEGACY_ROM = 4'h1,
      CAT_SYS_DEP = 4'h2,
      CAT_THIRD_PARTY = 4'h3,
      CAT_MAKER = 4'h4,
      CAT_LINK = 4'h5,
      CAT_TEXT = 4'h6,
      CAT_NET_ADDR = 4'h7,
      CAT_HW_REV = 4'h8,
      CAT_CHECKSUM = 4'h9,
      CAT_RESERVED = 4'hf
   } eci_cat_t;

   // Directory builder states.
   typedef enum logic [1:0] {
      B_IDLE = 2'b01,
      B_WRITE = 2'b10
   } eci_bstate_t;
endpackage : eci_pkg

//--- rtl/eci_sync.sv
// Three-stage synchroniser for a vector of pins; a bit changes once stages two and three agree.
// Assumes the inputs are asynchronous to clk and the reset value is a constant.
`timescale 1ns/1ps
module eci_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] rawIn,
   output logic [WIDTH-1:0] stableOut
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ==========================================================
   // Shift chain; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= rawIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Each bit moves only when two stages agree, which filters a single-sample glitch.
   for (genvar i = 0; i < WIDTH; i++) begin : gBit
      always_ff @(posedge clk) begin
         if (reset) begin
            stableOut[i] <= RST_VAL[i];
         end else if (s2_q[i] == s3_q[i]) begin
            stableOut[i] <= s2_q[i];
         end
      end
   end
endmodule : eci_sync

//--- rtl/eci_card_top.sv
// Card identity block: identity store with directory builder, host identity decode, AXI4-Lite slave.
// Assumes host strobes arrive asynchronously and are far longer than three clk periods.
//
// Behaviour
// (RULE1) Entry type byte first, valid class bit set.
// (RULE2) Class 0: loader, legacy image, system dependent.
// (RULE3) Classes 1, 2 loader; class 2 third party.
// (RULE4) Class 6 subtypes are manufacturer specific.
// (RULE5) Class 7 subtype 0 links another directory.
// (RULE6) Device data subtypes 1-6 point to text.
// (RULE7) Subtypes 7-9 address, revision, checksum; rest reserved.
// (RULE8) Simplest identity byte always served; the code serves it only while the enable bit is set, which reset clears.
// (RULE9) Identity decoded only in synchronous cycles.
// (RULE10) Non-extended enable ignores the direction line.
// (RULE11) Extended identity fits 32 by 8 store.
// (RULE12) Paged store selected through a page register.
// (RULE13) Cycle speed chosen by distinct address region.
// (RULE14) Host drops read buffer enable on withdrawal.
// (RULE15) Host stretches cycle until request returns.
// (RULE16) Card access unchanged by host stretching.
// (RULE17) Stretched write: enables released before stretch.
// (RULE18) Stretched read: data latched before stretch.
// (RULE19) Host controller makes card strobes and grant.
// (RULE20) Strobes follow bus clock, no reference phase.
// (RULE21) Late withdrawal extends host cycle one period.
// (RULE22) Entry is type, 3-byte size, 4-byte start.
// (RULE23) Directory ends with four zero bytes.
// (RULE24) Host skips reserved entries without error.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eci_regs.svh"
module eci_card_top #(
   parameter int STORE_AW = 10,
   parameter int ID_BYTES = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cardSelectStrobe_n,
   input wire logic cardReadStrobe_n,
   input wire logic cardWriteStrobe_n,
   input wire logic cardReadNotWrite,
   input wire logic busClock8mhz,
   input wire logic [15:0] cardAddr,
   input wire logic [7:0] cardDataIn,
   output logic [7:0] cardDataOut,
   output logic cardDataOe
);
   localparam int PAGE_W = STORE_AW - 8;

   // ==========================================================
   // Pin synchronisation.
   eci_pkg::eci_pins_t pins;
   logic [28:0] pinsVec;
   eci_sync #(.WIDTH(29), .RST_VAL(`ECI_PINS_IDLE)) u_eci_sync (
      .clk(clk),
      .reset(reset),
      .rawIn({cardSelectStrobe_n, cardReadStrobe_n, cardWriteStrobe_n, cardReadNotWrite,
              busClock8mhz, cardAddr, cardDataIn}),
      .stableOut(pinsVec)
   );
   assign pins = pinsVec;

   // ==========================================================
   // Storage and software-visible state.
   logic [7:0] store [2**STORE_AW];
   logic [1:0] mode_q;
   logic enable_q;
   logic [STORE_AW-1:0] ptr_q;
   logic [7:0] type_q;
   logic [23:0] size_q;
   logic [31:0] start_q;
   eci_pkg::eci_bstate_t bstate_q;
   logic [2:0] bcnt_q;
   logic bterm_q;
   eci_pkg::eci_cat_t lastCat_q;
   logic [PAGE_W-1:0] page_q;
   logic [7:0] hostCount_q;

   // Classification of a type byte; the valid class bit is assumed set by the builder.
   function automatic eci_pkg::eci_cat_t classify(input logic [7:0] t);
      eci_pkg::eci_cat_t c;
      c = eci_pkg::CAT_RESERVED;
      case (t[6:4])
         3'h0: begin
            if (t[3:0] == 4'h0) c = eci_pkg::CAT_LOADER; // RULE2
            else if (t[3:0] == 4'h1) c = eci_pkg::CAT_LEGACY_ROM; // RULE2
            else c = eci_pkg::CAT_SYS_DEP; // RULE2
         end
         3'h1, 3'h2: begin
            if (t[3:0] == 4'h0) c = eci_pkg::CAT_LOADER; // RULE3
            else if (t[6:4] == 3'h2 && t[3:0] == 4'h3) c = eci_pkg::CAT_THIRD_PARTY; // RULE3
         end
         3'h6: c = eci_pkg::CAT_MAKER; // RULE4
         3'h7: begin
            if (t[3:0] == 4'h0) c = eci_pkg::CAT_LINK; // RULE5
            else if (t[3:0] <= 4'h6) c = eci_pkg::CAT_TEXT; // RULE6
            else if (t[3:0] == 4'h7) c = eci_pkg::CAT_NET_ADDR; // RULE7
            else if (t[3:0] == 4'h8) c = eci_pkg::CAT_HW_REV; // RULE7
            else if (t[3:0] == 4'h9) c = eci_pkg::CAT_CHECKSUM; // RULE7
         end
         default: c = eci_pkg::CAT_RESERVED; // RULE3
      endcase
      return c;
   endfunction : classify

   // Byte k of the entry being built: type, then size low first, then start low first.
   function automatic logic [7:0] entryByte(input logic [2:0] k, input logic [7:0] t,
                                            input logic [23:0] s, input logic [31:0] a);
      logic [7:0] b;
      b = 8'h00;
      case (k)
         3'h0: b = t | `ECI_TYPE_VALID; // RULE1
         3'h1: b = s[7:0]; // RULE22
         3'h2: b = s[15:8];
         3'h3: b = s[23:16];
         3'h4: b = a[7:0];
         3'h5: b = a[15:8];
         3'h6: b = a[23:16];
         default: b = a[31:24];
      endcase
      return b;
   endfunction : entryByte

   // ==========================================================
   // AXI4-Lite write channels; address and data are taken in either order.
   logic awHave_q;
   logic wHave_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic doWrite;
   logic wrMapped;
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   assign wrMapped = awAddr_q[7:5] == 3'h0 && awAddr_q[1:0] == 2'h0;

   always_ff @(posedge clk) begin
      if (reset) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ECI_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `ECI_RESP_OKAY : `ECI_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Register writes honour the low byte lane for byte fields and all lanes for size and start; pointer writes ignore the strobes.
   logic [31:0] wMask;
   logic wrCtrl;
   logic wrPtr;
   logic wrData;
   logic wrCmd;
   logic busy;
   assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   assign busy = bstate_q == eci_pkg::B_WRITE;
   assign wrCtrl = doWrite && awAddr_q == `ECI_OFF_CTRL && wStrb_q[0];
   assign wrPtr = doWrite && awAddr_q == `ECI_OFF_PTR && !busy;
   assign wrData = doWrite && awAddr_q == `ECI_OFF_DATA && wStrb_q[0] && !busy;
   assign wrCmd = doWrite && awAddr_q == `ECI_OFF_CMD && wStrb_q[0] && !busy;

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q <= `ECI_MODE_NONEXT; // RULE8
         enable_q <= 1'b0;
         type_q <= 8'h00;
         size_q <= 24'h00_0000;
         start_q <= 32'h0000_0000;
      end else if (doWrite) begin
         if (wrCtrl) begin
            mode_q <= wData_q[1:0];
            enable_q <= wData_q[`ECI_CTRL_EN_BIT];
         end
         if (awAddr_q == `ECI_OFF_TYPE && wStrb_q[0] && !busy) type_q <= wData_q[7:0];
         if (awAddr_q == `ECI_OFF_SIZE && !busy) size_q <= (size_q & ~wMask[23:0]) | (wData_q[23:0] & wMask[23:0]);
         if (awAddr_q == `ECI_OFF_START && !busy) start_q <= (start_q & ~wMask) | (wData_q & wMask);
      end
   end

   // ==========================================================
   // Directory builder: one store byte per cycle, eight for an entry or four zeros to end the list.
   logic storeWe;
   logic [7:0] storeWd;
   always_comb begin
      storeWe = wrData || busy;
      storeWd = wData_q[7:0];
      if (busy) storeWd = bterm_q ? 8'h00 : entryByte(bcnt_q, type_q, size_q, start_q); // RULE23
   end

   always_ff @(posedge clk) begin
      if (storeWe) store[ptr_q] <= storeWd;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bstate_q <= eci_pkg::B_IDLE;
         bcnt_q <= 3'h0;
         bterm_q <= 1'b0;
         ptr_q <= '0;
         lastCat_q <= eci_pkg::CAT_RESERVED;
      end else begin
         if (wrPtr) ptr_q <= wData_q[STORE_AW-1:0];
         else if (storeWe) ptr_q <= ptr_q + 1'b1;
         case (bstate_q)
            eci_pkg::B_IDLE: begin
               if (wrCmd && wData_q[`ECI_CMD_COMMIT_BIT]) begin
                  bstate_q <= eci_pkg::B_WRITE;
                  bterm_q <= 1'b0;
                  bcnt_q <= 3'h0;
                  lastCat_q <= classify(type_q);
               end else if (wrCmd && wData_q[`ECI_CMD_TERM_BIT]) begin
                  bstate_q <= eci_pkg::B_WRITE;
                  bterm_q <= 1'b1;
                  bcnt_q <= 3'h0;
               end
            end
            eci_pkg::B_WRITE: begin
               bcnt_q <= bcnt_q + 3'h1;
               if (bcnt_q == (bterm_q ? `ECI_TERM_LAST : `ECI_ENTRY_LAST)) begin // RULE22 RULE23
                  bstate_q <= eci_pkg::B_IDLE;
               end
            end
            default: bstate_q <= eci_pkg::B_IDLE;
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite read channel; one read in flight, answer one cycle after the address is taken.
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      case (s_axi_araddr)
         `ECI_OFF_CTRL: rdMux = {29'h0, enable_q, mode_q};
         `ECI_OFF_STATUS: rdMux = {8'h00, hostCount_q, 8'(page_q), 3'h0, lastCat_q, busy};
         `ECI_OFF_PTR: rdMux = 32'(ptr_q);
         `ECI_OFF_DATA: rdMux = {24'h00_0000, store[ptr_q]};
         `ECI_OFF_TYPE: rdMux = {24'h00_0000, type_q};
         `ECI_OFF_SIZE: rdMux = {8'h00, size_q};
         `ECI_OFF_START: rdMux = start_q;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ECI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0) ? `ECI_RESP_OKAY : `ECI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Host identity decode. Only the synchronous region answers, so other speeds never see us.
   logic speedSync;
   logic selActive;
   logic rnwOk;
   logic readReq;
   logic [7:0] idx;
   logic [STORE_AW-1:0] phys;
   logic idxValid;
   assign idx = pins.addr[7:0];
   assign speedSync = pins.addr[15:14] == `ECI_SPEED_SYNC; // RULE9 RULE13
   assign selActive = !pins.selN && speedSync && enable_q;
   assign rnwOk = (mode_q == `ECI_MODE_NONEXT) ? 1'b1 : pins.rnw; // RULE10
   assign readReq = selActive && !pins.rdN && rnwOk;

   // Direct bytes sit at the bottom; beyond them the page register supplies the high address bits.
   always_comb begin
      phys = STORE_AW'(idx);
      idxValid = 1'b0;
      case (mode_q)
         `ECI_MODE_NONEXT: idxValid = idx == 8'h00; // RULE8
         `ECI_MODE_EXT: idxValid = 32'(idx) < ID_BYTES; // RULE11
         `ECI_MODE_PAGED: begin
            idxValid = 1'b1;
            if (32'(idx) >= ID_BYTES) phys = {page_q, idx}; // RULE12
         end
         default: idxValid = 1'b0;
      endcase
   end

   // The card answers only while its own strobes stand; host stretching later changes nothing here.
   always_ff @(posedge clk) begin
      if (reset) begin
         cardDataOut <= 8'h00;
         cardDataOe <= 1'b0;
      end else begin
         cardDataOe <= readReq; // RULE16
         cardDataOut <= (readReq && idxValid) ? store[phys] : 8'h00;
      end
   end

   // Bus clock edges are found by sampling; no reference clock is used at all.
   logic clkPrev_q;
   logic selPrev_q;
   logic wrDone_q;
   logic clkRise;
   logic pageWrite;
   assign clkRise = pins.busClock && !clkPrev_q; // RULE20
   assign pageWrite = selActive && !pins.wrN && !pins.rnw && !wrDone_q && clkRise
                      && idx == `ECI_PAGE_IDX && mode_q == `ECI_MODE_PAGED; // RULE12

   always_ff @(posedge clk) begin
      if (reset) begin
         clkPrev_q <= 1'b0;
         selPrev_q <= 1'b0;
         wrDone_q <= 1'b0;
         page_q <= '0;
         hostCount_q <= 8'h00;
      end else begin
         clkPrev_q <= pins.busClock;
         selPrev_q <= selActive;
         if (selActive && !selPrev_q) hostCount_q <= hostCount_q + 8'h01;
         if (pins.wrN) wrDone_q <= 1'b0;
         else if (pageWrite) wrDone_q <= 1'b1;
         if (pageWrite) page_q <= pins.data[PAGE_W-1:0];
      end
   end

   // ==========================================================
   // Checks next to the logic they guard.
   a_type_valid_bit: assert property (@(posedge clk) disable iff (reset) // RULE1
      busy && !bterm_q && bcnt_q == 3'h0 |-> storeWd[7] == 1'b1)
      else $error("Entry type byte written without valid class bit.");
   a_entry_eight: assert property (@(posedge clk) disable iff (reset) // RULE22
      bstate_q == eci_pkg::B_IDLE && wrCmd && wData_q[0] |=> busy [*8] ##1 !busy)
      else $error("Entry did not take exactly eight store bytes.");
   a_term_zeros: assert property (@(posedge clk) disable iff (reset) // RULE23
      busy && bterm_q |-> storeWe && storeWd == 8'h00 && bcnt_q <= 3'h3)
      else $error("Terminator wrote a nonzero byte or ran long.");
   a_sync_only: assert property (@(posedge clk) disable iff (reset) // RULE9
      cardDataOe |-> $past(pins.addr[15:14]) == `ECI_SPEED_SYNC)
      else $error("Card drove data outside the synchronous region.");
   a_oe_ends_select: assert property (@(posedge clk) disable iff (reset) // RULE16
      pins.selN |=> !cardDataOe)
      else $error("Card kept driving after its select ended.");
   a_nonext_rnw: assert property (@(posedge clk) disable iff (reset) // RULE10
      mode_q == `ECI_MODE_NONEXT && selActive && !pins.rdN |=> cardDataOe)
      else $error("Non-extended read was gated by the direction line.");
   a_page_capture: assert property (@(posedge clk) disable iff (reset) // RULE12
      pageWrite |=> page_q == $past(pins.data[PAGE_W-1:0]) && wrDone_q)
      else $error("Page register did not take the host data.");
   a_ext_bound: assert property (@(posedge clk) disable iff (reset) // RULE11
      readReq && mode_q == `ECI_MODE_EXT && 32'(idx) >= ID_BYTES |=> cardDataOut == 8'h00)
      else $error("Extended identity answered beyond its store.");
   a_bresp_follows: assert property (@(posedge clk) disable iff (reset)
      doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("Write response did not follow the write.");
   a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data changed before it was taken.");
endmodule : eci_card_top

//--- dv/eci_host_model.sv
// Host I/O controller model: makes card strobes, the bus clock and host write data.
// Assumes the bench clock clk and task calls from one process at a time.
`timescale 1ns/1ps
module eci_host_model (
   input wire logic clk,
   output logic selN,
   output logic rdN,
   output logic wrN,
   output logic rnw,
   output logic busClk,
   output logic [15:0] addr,
   output logic [7:0] dOut,
   input wire logic [7:0] dIn,
   input wire logic dOe
);
   // ==========================================================
   // Idle pins and a free bus clock, offset so no phase with clk is implied.
   initial begin
      selN = 1'b1;
      rdN = 1'b1;
      wrN = 1'b1;
      rnw = 1'b1;
      addr = 16'h0000;
      dOut = 8'h00;
      busClk = 1'b0;
      #37;
      forever #160 busClk = ~busClk;
   end

   // One card read; the tail idle span stands for host stretching after the access.
   task automatic hostRead(input logic [15:0] a, input logic r, output logic [7:0] d, output logic seen);
      d = 8'h00;
      seen = 1'b0;
      @(posedge clk);
      addr <= a;
      rnw <= r;
      repeat (2) @(posedge clk);
      selN <= 1'b0;
      rdN <= 1'b0;
      repeat (16) begin
         @(posedge clk);
         if (dOe === 1'b1) begin
            seen = 1'b1;
            d = dIn;
         end
      end
      selN <= 1'b1;
      rdN <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : hostRead

   // One card write; data line takes the inverse value once released.
   task automatic hostWrite(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rnw <= 1'b0;
      dOut <= v;
      repeat (2) @(posedge clk);
      selN <= 1'b0;
      wrN <= 1'b0;
      repeat (24) @(posedge clk);
      selN <= 1'b1;
      wrN <= 1'b1;
      dOut <= ~v;
      rnw <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : hostWrite
endmodule : eci_host_model

//--- dv/eci_card_top_tb.sv
// Self-checking bench: AXI4-Lite register tasks and host card cycles against the identity block.
// Assumes the design answers every request within a few dozen clocks.
`timescale 1ns/1ps
`include "eci_regs.svh"
module eci_card_top_tb;
   // ==========================================================
   // Signals and expected tables.
   logic clk, reset;
   logic [7:0] awaddr, araddr, hostData, cardData;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic selN, rdN, wrN, rnw, busClk, cardOe;
   logic [15:0] cardAddr;
   int errorCnt = 0;
   int testsRun = 0;
   localparam logic [1:0] OK = `ECI_RESP_OKAY;
   localparam logic [63:0] ENTRY = 64'h7654_3210_abcd_ef80;
   localparam logic [11:0] CASES [14] = '{12'h000, 12'h011, 12'h052, 12'h100, 12'h13f, 12'h233, 12'h40f,
      12'h694, 12'h705, 12'h736, 12'h777, 12'h788, 12'h799, 12'h7cf};

   eci_card_top u_eci_card_top (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cardSelectStrobe_n(selN),
      .cardReadStrobe_n(rdN), .cardWriteStrobe_n(wrN), .cardReadNotWrite(rnw), .busClock8mhz(busClk),
      .cardAddr(cardAddr), .cardDataIn(hostData), .cardDataOut(cardData), .cardDataOe(cardOe));

   eci_host_model u_eci_host_model (.clk(clk), .selN(selN), .rdN(rdN), .wrN(wrN), .rnw(rnw),
      .busClk(busClk), .addr(cardAddr), .dOut(hostData), .dIn(cardData), .dOe(cardOe));

   // ==========================================================
   // Clock, watchdog and shared tasks.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs well under a tenth of this span.
   initial begin
      #1000000;
      errorCnt++;
      testDone();
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         errorCnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic testDone();
      if (errorCnt == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : testDone

   // Address and data offered together; an extra edge keeps ready drops apart from the next raise.
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [2:0] r;
      r = 3'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = {1'b1, bresp};
            break;
         end
      end
      bready <= 1'b0;
      @(posedge clk);
      chk("bresp", {29'h0, 1'b1, er}, {29'h0, r});
   endtask : axiWr

   // Read ready rises only once valid is seen, so the slave must hold its answer for a cycle.
   task automatic axiRd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      logic [2:0] r;
      r = 3'h0;
      d = 32'h0;
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready === 1'b1) begin
            r = {1'b1, rresp};
            d = rdata;
            break;
         end
         if (rvalid === 1'b1) rready <= 1'b1;
      end
      rready <= 1'b0;
      @(posedge clk);
      chk("rresp", {29'h0, 1'b1, er}, {29'h0, r});
   endtask : axiRd

   // Issues a builder command and polls until busy clears; returns the last status word.
   task automatic build(input logic [1:0] c, output logic [31:0] d);
      axiWr(`ECI_OFF_CMD, {30'h0, c}, OK);
      for (int n = 0; n < 20; n++) begin
         axiRd(`ECI_OFF_STATUS, OK, d);
         if (d[0] === 1'b0) break;
      end
      chk("busy", 32'h0, {31'h0, d[0]});
   endtask : build

   task automatic hostChk(input logic [15:0] a, input logic r, input logic [8:0] e);
      logic [7:0] hb;
      logic seen;
      u_eci_host_model.hostRead(a, r, hb, seen);
      chk("card read", {23'h0, e}, {23'h0, seen, hb});
   endtask : hostChk

   // ==========================================================
   // Main sequence.
   initial begin
      logic [31:0] d;
      reset = 1'b1;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      axiRd(`ECI_OFF_CTRL, OK, d);
      chk("ctrl", 32'h0, d);
      axiRd(8'h20, `ECI_RESP_SLVERR, d);
      chk("unmapped", 32'h0, d);
      axiWr(8'h22, 32'h5, `ECI_RESP_SLVERR);
      axiWr(`ECI_OFF_SIZE, 32'h00ab_cdef, OK);
      axiWr(`ECI_OFF_START, 32'h7654_3210, OK);
      for (int i = 0; i < 14; i++) begin
         axiWr(`ECI_OFF_TYPE, {24'h0, CASES[i][11:4]}, OK);
         build(2'h1, d);
         chk("category", {28'h0, CASES[i][3:0]}, {28'h0, d[4:1]});
      end
      build(2'h2, d);
      for (int i = 0; i < 12; i++) begin
         axiWr(`ECI_OFF_PTR, 32'((i < 8) ? i : 104 + i), OK);
         axiRd(`ECI_OFF_DATA, OK, d);
         chk("store", (i < 8) ? {24'h0, ENTRY[8*i +: 8]} : 32'h0, d);
      end
      axiWr(`ECI_OFF_CTRL, 32'h5, OK);
      hostChk(16'hc000, 1'b1, 9'h180);
      hostChk(16'hc001, 1'b1, 9'h1ef);
      hostChk(16'h4000, 1'b1, 9'h000);
      hostChk(16'hc020, 1'b1, 9'h100);
      axiWr(`ECI_OFF_CTRL, 32'h4, OK);
      hostChk(16'hc000, 1'b0, 9'h180);
      hostChk(16'hc001, 1'b1, 9'h100);
      axiWr(`ECI_OFF_PTR, 32'h120, OK);
      axiWr(`ECI_OFF_DATA, 32'h5a, OK);
      axiWr(`ECI_OFF_CTRL, 32'h6, OK);
      u_eci_host_model.hostWrite(16'hc000, 8'h01);
      axiRd(`ECI_OFF_STATUS, OK, d);
      chk("page", 32'h1, {24'h0, d[15:8]});
      chk("host count", 32'h6, {24'h0, d[23:16]});
      hostChk(16'hc020, 1'b1, 9'h15a);
      testDone();
   end
endmodule : eci_card_top_tb
